// ### rtl/ffs_flags.sv
/*
 * Status flags, reset-time options, byte order and offset parity handling.
 * Assumes write and read clocks arrive as pins far slower than clk_in.
 */
// Operation
// R1 - Byte order pin caught during master reset
// R2 - Big order: most significant half first
// R3 - Little order: least significant half first
// R4 - Flag timing pin caught during master reset
// R5 - Async: almost-empty low on read, high write
// R6 - Async: almost-full low on write, high read
// R7 - Sync: almost-empty moves on read edges only
// R8 - Sync: almost-full moves on write edges only
// R9 - Parity placement pin caught during master reset
// R10 - Interspersed: bits 8,17,26,35 dropped from offset
// R11 - Plain: low 32 bits used, top ignored
// R12 - Parity choice never touches buffered data
// R13 - Standard full flag low when buffer full
// R14 - Fall-through input flag high when no space
// R15 - Input flag counts the output register word
// R16 - Full flag on write edges, two stages
// R17 - Standard empty flag low while buffer empty
// R18 - Output-ready low with data, high on read
// R19 - Last word stays shown, reads then ignored
// R20 - Empty flag two stages, output-ready three
// R21 - Standard almost-full at depth minus offset
// R22 - Fall-through almost-full at depth+1 minus offset
// R23 - Standard almost-empty at count within offset
// R24 - Fall-through almost-empty at offset plus one
// R25 - Fall-through select caught during master reset
// R26 - First word shown after three read edges
// R27 - Full flag frees within two write edges
// R28 - Empty flag frees within two read edges
// R29 - Offsets come from registers outside here
// R30 - Crossing values synchronised, flags change cleanly
`timescale 1ns/1ps
module ffs_flags
	import ffs_pkg::*;
#(
	parameter int DEPTH = ffs_pkg::DEPTH_DEF
) (
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       wclk_pin_in,
	input  wire logic                       rclk_pin_in,
	input  wire logic                       write_en_n_in,
	input  wire logic                       read_en_n_in,
	input  wire logic                       master_reset_n_in,
	input  wire logic                       partial_reset_n_in,
	input  wire logic                       byte_order_sel_n_in,
	input  wire logic                       flag_timing_sel_in,
	input  wire logic                       parity_placement_sel_in,
	input  wire logic                       fall_through_sel_in,
	input  wire logic                       narrow_out_sel_in,
	input  wire logic                       offset_load_in,
	input  wire logic [ffs_pkg::DATA_W-1:0] data_in,
	input  wire logic [ffs_pkg::DATA_W-1:0] offset_word_in,
	input  wire logic [ffs_pkg::OFS_W-1:0]  full_offset_in,
	input  wire logic [ffs_pkg::OFS_W-1:0]  empty_offset_in,
	output logic      [ffs_pkg::DATA_W-1:0] data_out,
	output logic      [ffs_pkg::OFS_W-1:0]  parsed_offset_out,
	output logic                            full_flag_n_out,
	output logic                            input_space_n_out,
	output logic                            empty_flag_n_out,
	output logic                            output_ready_n_out,
	output logic                            almost_full_flag_n_out,
	output logic                            almost_empty_flag_n_out,
	output logic                            fall_through_mode_out
);
	import ffs_pkg::*;

	localparam int LW = $clog2(DEPTH + 1);

	ffs_fifo_if #(.W(DATA_W), .D(DEPTH)) buf_if ();

	logic [SYNC_W-1:0] pins_s;
	logic              wclk_s;
	logic              rclk_s;
	logic              wen_n_s;
	logic              ren_n_s;
	logic              mreset_n_s;
	logic              preset_n_s;
	logic              order_n_s;
	logic              timing_s;
	logic              parity_s;
	logic              fall_s;
	logic              narrow_s;
	logic              ofs_load_s;
	logic [DATA_W-1:0] data_s;
	logic [DATA_W-1:0] ofs_word_s;
	logic              wclk_d_reg;
	logic              rclk_d_reg;
	logic              wr_edge;
	logic              rd_edge;
	logic              flush;
	ffs_mode_e         mode_reg;
	logic              little_reg;
	logic              sync_tim_reg;
	logic              inter_reg;
	logic              narrow_reg;
	logic              fall;
	logic [SUM_W-1:0]  total;
	logic [SUM_W-1:0]  depth_eff;
	logic              full_raw;
	logic              af_raw;
	logic              ae_raw;
	logic              full_s1_reg;
	logic              full_s2_reg;
	logic              ne_s1_reg;
	logic              ne_s2_reg;
	logic              out_valid_reg;
	logic              pend_reg;
	logic              half_reg;
	logic              held_reg;
	logic [DATA_W-1:0] word_reg;
	logic              rd_req;
	logic              adv_half;
	logic              pop_std;
	logic              pop_fall;
	logic              paf_n_reg;
	logic              pae_n_reg;

	// Pins are slow against clk_in, so edges are found after resampling.
	ffs_sync #(.W(SYNC_W)) u_sync ( // R30
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.d_in     ({wclk_pin_in, rclk_pin_in, write_en_n_in, read_en_n_in,
			master_reset_n_in, partial_reset_n_in, byte_order_sel_n_in,
			flag_timing_sel_in, parity_placement_sel_in,
			fall_through_sel_in, narrow_out_sel_in, data_in,
			offset_word_in, offset_load_in}),
		.q_out    (pins_s)
	);

	assign {wclk_s, rclk_s, wen_n_s, ren_n_s, mreset_n_s, preset_n_s,
		order_n_s, timing_s, parity_s, fall_s, narrow_s, data_s,
		ofs_word_s, ofs_load_s} = pins_s;

	ffs_fifo #(.W(DATA_W), .D(DEPTH)) u_fifo (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.port_if  (buf_if.buf_side)
	);

	// Picks the half shown on a narrow bus; full width passes untouched.
	function automatic logic [DATA_W-1:0] pick_half(
		input logic [DATA_W-1:0] w, input logic second,
		input logic little, input logic narrow);
		logic hi;
		hi = (second == little);
		if (!narrow) begin
			pick_half = w;
		end else if (hi) begin
			pick_half = {{HALF_W{1'b0}}, w[DATA_W-1:HALF_W]};
		end else begin
			pick_half = {{HALF_W{1'b0}}, w[HALF_W-1:0]};
		end
	endfunction : pick_half

	assign wr_edge = wclk_s && !wclk_d_reg;
	assign rd_edge = rclk_s && !rclk_d_reg;
	assign flush   = !mreset_n_s || !preset_n_s;
	assign fall    = (mode_reg == FFS_FALL);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wclk_d_reg <= 1'b0;
			rclk_d_reg <= 1'b0;
		end else begin
			wclk_d_reg <= wclk_s;
			rclk_d_reg <= rclk_s;
		end
	end

	// Options follow their pins while master reset is held, then freeze.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_reg     <= FFS_STD;
			little_reg   <= 1'b0;
			sync_tim_reg <= 1'b0;
			inter_reg    <= 1'b0;
			narrow_reg   <= 1'b0;
		end else if (!mreset_n_s) begin
			mode_reg     <= fall_s ? FFS_FALL : FFS_STD; // R25
			little_reg   <= order_n_s; // R1
			sync_tim_reg <= timing_s; // R4
			inter_reg    <= parity_s; // R9
			narrow_reg   <= narrow_s;
		end
	end

	// Only the offset path looks at parity placement; data never does.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			parsed_offset_out <= '0;
		end else if (wr_edge && ofs_load_s) begin
			if (inter_reg) begin
				parsed_offset_out <= {ofs_word_s[PAR_B3-1:PAR_B2+1],
					ofs_word_s[PAR_B2-1:PAR_B1+1],
					ofs_word_s[PAR_B1-1:PAR_B0+1],
					ofs_word_s[PAR_B0-1:0]}; // R10
			end else begin
				parsed_offset_out <= ofs_word_s[OFS_W-1:0]; // R11
			end
		end
	end

	assign buf_if.clear    = flush;
	assign buf_if.wr_data  = data_s; // R12
	assign buf_if.wr_valid = wr_edge && !wen_n_s && !ofs_load_s
		&& !full_s2_reg; // R13 R14

	// Occupancy in fall-through mode includes the word on the outputs.
	// A word between its pop and the output register still counts.
	assign total = SUM_W'(buf_if.level)
		+ SUM_W'(fall && (out_valid_reg || pend_reg)); // R15
	assign depth_eff = fall ? SUM_W'(DEPTH + 1) : SUM_W'(DEPTH);
	assign full_raw  = (total >= depth_eff); // R13 R14
	assign af_raw    = (total + SUM_W'(full_offset_in) >= depth_eff); // R21 R22 R29
	assign ae_raw    = fall
		? (total <= SUM_W'(empty_offset_in) + SUM_W'(1)) // R24
		: (total <= SUM_W'(empty_offset_in)); // R23

	// Two write-edge stages keep a late read from glitching the pin.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			full_s1_reg <= 1'b0;
			full_s2_reg <= 1'b0;
		end else if (flush) begin
			full_s1_reg <= 1'b0;
			full_s2_reg <= 1'b0;
		end else if (wr_edge) begin
			full_s1_reg <= full_raw; // R16 R27
			full_s2_reg <= full_s1_reg;
		end
	end

	assign full_flag_n_out   = fall ? FLAG_OFF : !full_s2_reg; // R13
	assign input_space_n_out = fall ? full_s2_reg : FLAG_OFF; // R14

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ne_s1_reg <= 1'b0;
			ne_s2_reg <= 1'b0;
		end else if (flush) begin
			ne_s1_reg <= 1'b0;
			ne_s2_reg <= 1'b0;
		end else if (rd_edge) begin
			ne_s1_reg <= buf_if.rd_valid; // R20 R28
			ne_s2_reg <= ne_s1_reg;
		end
	end

	assign empty_flag_n_out   = fall ? FLAG_OFF : ne_s2_reg; // R17
	assign output_ready_n_out = fall ? !out_valid_reg : FLAG_OFF; // R18

	// Read side: a narrow bus shows the second half before popping again.
	assign rd_req   = rd_edge && !ren_n_s;
	assign adv_half = rd_req && narrow_reg && !half_reg
		&& (fall ? out_valid_reg : held_reg); // R2 R3
	assign pop_std  = !fall && rd_req && !adv_half && ne_s2_reg
		&& buf_if.rd_valid; // R17
	assign pop_fall = fall && rd_edge && !pend_reg && ne_s2_reg
		&& buf_if.rd_valid && !adv_half
		&& (!out_valid_reg || !ren_n_s); // R26
	assign buf_if.rd_ready = pop_std || pop_fall;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_reg <= 1'b0;
		end else begin
			pend_reg <= buf_if.rd_ready && !flush;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_valid_reg <= 1'b0;
		end else if (flush) begin
			out_valid_reg <= 1'b0;
		end else if (pend_reg && fall) begin
			out_valid_reg <= 1'b1; // R18 R20
		end else if (fall && rd_req && out_valid_reg && !adv_half
			&& !pop_fall) begin
			out_valid_reg <= 1'b0; // R18 R19
		end
	end

	// The last word stays on the pins after it is read out.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_reg <= DATA_RST;
			data_out <= DATA_RST;
			half_reg <= 1'b0;
			held_reg <= 1'b0;
		end else if (flush) begin
			half_reg <= 1'b0;
			held_reg <= 1'b0;
		end else if (pend_reg) begin
			word_reg <= buf_if.rd_data;
			data_out <= pick_half(buf_if.rd_data, 1'b0, little_reg,
				narrow_reg); // R2 R3
			half_reg <= 1'b0;
			held_reg <= 1'b1;
		end else if (adv_half) begin
			data_out <= pick_half(word_reg, 1'b1, little_reg, narrow_reg);
			half_reg <= 1'b1;
		end
	end

	// Async timing moves each flag from both sides; sync uses one side.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			paf_n_reg <= FLAG_OFF;
		end else if (flush) begin
			paf_n_reg <= FLAG_OFF;
		end else if (sync_tim_reg) begin
			if (wr_edge) begin
				paf_n_reg <= !af_raw; // R8
			end
		end else if (wr_edge && af_raw) begin
			paf_n_reg <= FLAG_ON; // R6
		end else if (rd_edge && !af_raw) begin
			paf_n_reg <= FLAG_OFF; // R6
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pae_n_reg <= FLAG_ON;
		end else if (flush) begin
			pae_n_reg <= FLAG_ON;
		end else if (sync_tim_reg) begin
			if (rd_edge) begin
				pae_n_reg <= !ae_raw; // R7
			end
		end else if (rd_edge && ae_raw) begin
			pae_n_reg <= FLAG_ON; // R5
		end else if (wr_edge && !ae_raw) begin
			pae_n_reg <= FLAG_OFF; // R5
		end
	end

	assign almost_full_flag_n_out  = paf_n_reg;
	assign almost_empty_flag_n_out = pae_n_reg;
	assign fall_through_mode_out   = fall;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_wr_tick;
		wr_edge && !flush;
	endsequence
	sequence s_rd_tick;
		rd_edge && !flush;
	endsequence

	property p_full_blocks;
		(fall ? input_space_n_out : !full_flag_n_out) && !buf_if.rd_ready
			|=> buf_if.level <= $past(buf_if.level);
	endproperty
	a_full_blocks: assert property (p_full_blocks) // R13
		else $error("buffer grew while the full flag was set");

	property p_full_on_wedge;
		!flush && !$past(flush) && $changed(full_s2_reg)
			|-> $past(wr_edge);
	endproperty
	a_full_on_wedge: assert property (p_full_on_wedge) // R16
		else $error("full flag moved without a write edge");

	property p_full_two_stage;
		s_wr_tick |=> full_s2_reg == $past(full_s1_reg);
	endproperty
	a_full_two_stage: assert property (p_full_two_stage) // R16
		else $error("full flag skipped its second stage");

	property p_pae_sync;
		sync_tim_reg && !flush && !$past(flush) && $changed(pae_n_reg)
			|-> $past(rd_edge);
	endproperty
	a_pae_sync: assert property (p_pae_sync) // R7
		else $error("sync almost-empty moved off a read edge");

	property p_paf_sync;
		sync_tim_reg && !flush && !$past(flush) && $changed(paf_n_reg)
			|-> $past(wr_edge);
	endproperty
	a_paf_sync: assert property (p_paf_sync) // R8
		else $error("sync almost-full moved off a write edge");

	property p_pae_async;
		!sync_tim_reg && !flush && !$past(flush) && $fell(pae_n_reg)
			|-> $past(rd_edge && ae_raw);
	endproperty
	a_pae_async: assert property (p_pae_async) // R5
		else $error("async almost-empty fell off a read edge");

	property p_paf_async;
		!sync_tim_reg && !flush && !$past(flush) && $rose(paf_n_reg)
			|-> $past(rd_edge && !af_raw);
	endproperty
	a_paf_async: assert property (p_paf_async) // R6
		else $error("async almost-full rose off a read edge");

	property p_ready_with_data;
		fall && !flush && $fell(output_ready_n_out) |-> $past(pend_reg);
	endproperty
	a_ready_with_data: assert property (p_ready_with_data) // R18
		else $error("output-ready fell without a new word");

	property p_last_word_kept;
		fall && !out_valid_reg && !pend_reg |=> $stable(data_out);
	endproperty
	a_last_word_kept: assert property (p_last_word_kept) // R19
		else $error("output word changed while not ready");

	property p_empty_gate;
		!fall && !ne_s2_reg |-> !buf_if.rd_ready;
	endproperty
	a_empty_gate: assert property (p_empty_gate) // R17
		else $error("read taken while empty flag low");

	property p_ready_pipeline;
		s_rd_tick ##0 (fall && !out_valid_reg && !pend_reg && ne_s2_reg
			&& buf_if.rd_valid) |=> pend_reg ##1 !output_ready_n_out;
	endproperty
	a_ready_pipeline: assert property (p_ready_pipeline) // R26
		else $error("first word did not fall through");
endmodule : ffs_flags

// ### rtl/ffs_pkg.sv
/*
 * Shared constants for the status flag and reset option block.
 * Assumes a single system clock; every value here is used by name.
 */
package ffs_pkg;
	localparam int DATA_W    = 36;
	localparam int HALF_W    = 18;
	localparam int DEPTH_DEF = 16;
	localparam int OFS_W     = 32;
	localparam int SUM_W     = 34;
	localparam int SYNC_W    = 11 + 2 * DATA_W + 1;
	// Parity bit positions inside a parallel offset word.
	localparam int PAR_B0    = 8;
	localparam int PAR_B1    = 17;
	localparam int PAR_B2    = 26;
	localparam int PAR_B3    = 35;
	// Off and on levels of the active-low flag pins.
	localparam logic FLAG_OFF = 1'b1;
	localparam logic FLAG_ON  = 1'b0;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
	typedef enum logic {FFS_STD, FFS_FALL} ffs_mode_e;
endpackage : ffs_pkg

// ### rtl/ffs_fifo_if.sv
/*
 * Bundle between the flag logic and its word buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ffs_fifo_if #(
	parameter int W = 36,
	parameter int D = 16
);
	logic                   clear;
	logic                   wr_valid;
	logic                   wr_ready;
	logic [W-1:0]           wr_data;
	logic                   rd_valid;
	logic                   rd_ready;
	logic [W-1:0]           rd_data;
	logic [$clog2(D+1)-1:0] level;
	modport buf_side  (input clear, wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data, level);
	modport user_side (output clear, wr_valid, wr_data, rd_ready,
		input wr_ready, rd_valid, rd_data, level);
endinterface : ffs_fifo_if

// ### rtl/ffs_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes the pins are quasi-static against the system clock.
 */
`timescale 1ns/1ps
module ffs_sync #(
	parameter int W = 8
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_reg;

	// The first stage feeds only the second to keep metastability local.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_reg <= '0;
			q_out    <= '0;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule : ffs_sync

// ### rtl/ffs_fifo.sv
/*
 * Word buffer with registered read data and a live fill level.
 * Assumes the user never pushes when not ready nor pops when empty.
 */
`timescale 1ns/1ps
module ffs_fifo #(
	parameter int W = 36,
	parameter int D = 16
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	ffs_fifo_if.buf_side port_if
);
	localparam int PW = $clog2(D);
	localparam int LW = $clog2(D+1);

	logic [W-1:0]  mem [D];
	logic [PW-1:0] wptr_reg;
	logic [PW-1:0] rptr_reg;
	logic [LW-1:0] cnt_reg;
	logic          push;
	logic          pop;

	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		next_ptr = (p == PW'(D - 1)) ? '0 : p + 1'b1;
	endfunction : next_ptr

	assign port_if.wr_ready = (cnt_reg != LW'(D));
	assign port_if.rd_valid = (cnt_reg != '0);
	assign port_if.level    = cnt_reg;
	assign push = port_if.wr_valid && port_if.wr_ready;
	assign pop  = port_if.rd_ready && port_if.rd_valid;

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wptr_reg] <= port_if.wr_data;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port_if.rd_data <= '0;
		end else if (pop) begin
			port_if.rd_data <= mem[rptr_reg];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
		end else if (port_if.clear) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
		end else begin
			if (push) begin
				wptr_reg <= next_ptr(wptr_reg);
			end
			if (pop) begin
				rptr_reg <= next_ptr(rptr_reg);
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule : ffs_fifo

// ### dv/ffs_far_end.sv
/*
 * Writer and reader model that drives the clock pins, enables and data.
 * Assumes clk_in is the system clock; every pin moves on its falling edge.
 */
`timescale 1ns/1ps
module ffs_far_end (
	input  wire logic                       clk_in,
	output logic                            wclk_pin_out,
	output logic                            rclk_pin_out,
	output logic                            write_en_n_out,
	output logic                            read_en_n_out,
	output logic      [ffs_pkg::DATA_W-1:0] data_out
);
	import ffs_pkg::*;
	// Each pin phase lasts gap cycles; three is the default, though one cycle is enough for edge detection.
	int gap = 3;
	initial begin
		wclk_pin_out = 1'b0;
		rclk_pin_out = 1'b0;
		write_en_n_out = 1'b1;
		read_en_n_out = 1'b1;
		data_out = 36'h0_0000_0000;
	end
	task automatic pulse(input logic wr);
		repeat (gap) @(negedge clk_in);
		if (wr) wclk_pin_out = 1'b1;
		else rclk_pin_out = 1'b1;
		repeat (gap) @(negedge clk_in);
		if (wr) wclk_pin_out = 1'b0;
		else rclk_pin_out = 1'b0;
	endtask : pulse
	task automatic write_word(input logic en, input logic [DATA_W-1:0] d);
		@(negedge clk_in);
		write_en_n_out = ~en;
		data_out = d;
		pulse(1'b1);
		write_en_n_out = 1'b1;
		// A released bus shows the inverse of its last word, never a copy.
		data_out = ~d;
	endtask : write_word
	task automatic read_word(input logic en);
		@(negedge clk_in);
		read_en_n_out = ~en;
		pulse(1'b0);
		read_en_n_out = 1'b1;
	endtask : read_word
endmodule : ffs_far_end

// ### dv/tb_ffs_flags.sv
/*
 * Self-checking bench for the flag block with its writer and reader model.
 * Assumes the bench is the top; expectations follow a word count.
 */
`timescale 1ns/1ps
module tb_ffs_flags;
	import ffs_pkg::*;
	localparam int DEP = 16;
	logic              clk_in, rst_n_in, mrs_n, prs_n, bo_n, tim, par;
	logic              fts, nar, load, ft_mode;
	logic              wclk, rclk, wen_n, ren_n;
	logic              ff_n, ir_n, ef_n, or_n, af_n, ae_n, ftm;
	logic [DATA_W-1:0] din, dout, ofs_word, shown;
	logic [OFS_W-1:0]  parsed, m_ofs, n_ofs;
	logic [5:0]        flags;
	logic [31:0]       lfsr_q = 32'h0000_0022;
	logic [DATA_W-1:0] q[$];
	int                mismatches, n_compared, cnt;
	assign flags = {ff_n, ir_n, ef_n, or_n, af_n, ae_n};
	ffs_far_end u_ffs_far_end (.clk_in(clk_in), .wclk_pin_out(wclk),
		.rclk_pin_out(rclk), .write_en_n_out(wen_n),
		.read_en_n_out(ren_n), .data_out(din));
	ffs_flags #(.DEPTH(DEP)) u_ffs_flags (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .wclk_pin_in(wclk), .rclk_pin_in(rclk),
		.write_en_n_in(wen_n), .read_en_n_in(ren_n),
		.master_reset_n_in(mrs_n), .partial_reset_n_in(prs_n),
		.byte_order_sel_n_in(bo_n), .flag_timing_sel_in(tim),
		.parity_placement_sel_in(par), .fall_through_sel_in(fts),
		.narrow_out_sel_in(nar), .offset_load_in(load), .data_in(din),
		.offset_word_in(ofs_word), .full_offset_in(m_ofs),
		.empty_offset_in(n_ofs), .data_out(dout),
		.parsed_offset_out(parsed), .full_flag_n_out(ff_n),
		.input_space_n_out(ir_n), .empty_flag_n_out(ef_n),
		.output_ready_n_out(or_n), .almost_full_flag_n_out(af_n),
		.almost_empty_flag_n_out(ae_n), .fall_through_mode_out(ftm));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	function automatic logic [DATA_W-1:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return {lfsr_q[7:4], lfsr_q};
	endfunction : rnd
	function automatic logic [5:0] exp_flags(input int c);
		int top;
		top = DEP + int'(ft_mode);
		return {ft_mode | (c < DEP), ~ft_mode | (c >= top), ft_mode | (c != 0),
			~ft_mode | (c == 0), c < top - int'(m_ofs),
			c > int'(n_ofs) + int'(ft_mode)};
	endfunction : exp_flags
	function automatic logic [OFS_W-1:0] exp_parse(input logic [DATA_W-1:0] w,
		input logic p);
		return p ? {w[34:27], w[25:18], w[16:9], w[7:0]} : w[31:0];
	endfunction : exp_parse
	task automatic check(input logic [DATA_W-1:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic edges(input logic w);
		repeat (3) begin
			if (w) u_ffs_far_end.write_word(1'b0, 36'h0_0000_0000);
			else u_ffs_far_end.read_word(1'b0);
		end
		repeat (4) @(negedge clk_in);
	endtask : edges
	task automatic chk_flags();
		logic [5:0] e;
		edges(1'b1);
		edges(1'b0);
		e = exp_flags(cnt);
		check(flags[5:2], e[5:2]);
		check(flags[1:0], e[1:0]);
	endtask : chk_flags
	task automatic mreset(input logic ft, bo, nr, tm, pr);
		@(negedge clk_in);
		mrs_n = 1'b0;
		{fts, bo_n, nar, tim, par} = {ft, bo, nr, tm, pr};
		repeat (6) @(negedge clk_in);
		mrs_n = 1'b1;
		repeat (6) @(negedge clk_in);
		ft_mode = ft;
		cnt = 0;
		q.delete();
		check(ftm, ft);
	endtask : mreset
	task automatic wr(input logic [DATA_W-1:0] d);
		// Writes beyond capacity are dropped, so the model does not count them.
		if (cnt < DEP + int'(ft_mode)) begin
			if (ft_mode && cnt == 0) shown = d;
			q.push_back(d);
			cnt++;
		end
		u_ffs_far_end.write_word(1'b1, d);
		chk_flags();
	endtask : wr
	task automatic rd();
		if (cnt > 0) begin
			shown = q.pop_front();
			cnt--;
			if (ft_mode && cnt > 0) shown = q[0];
		end
		u_ffs_far_end.read_word(1'b1);
		chk_flags();
		check(dout, shown);
	endtask : rd
	initial begin
		#2_000_000;
		mismatches++;
		$display("mismatch at %0t: run did not finish", $time);
		print_verdict();
	end
	initial begin
		{rst_n_in, mrs_n, prs_n, bo_n, tim, par, fts, nar, load} = 9'h040;
		{ofs_word, shown, ft_mode} = '0;
		m_ofs = 32'h0000_0003;
		n_ofs = 32'h0000_0002;
		{mismatches, n_compared, cnt} = '0;
		repeat (12) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (2) @(negedge clk_in);
		check(flags, exp_flags(0));
		mreset(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		repeat (DEP + 1) wr(rnd());
		repeat (DEP + 1) rd();
		for (int k = 0; k < 2; k++) begin
			m_ofs = 32'h0000_0001 + (lfsr_q % 5);
			n_ofs = 32'h0000_0001 + (lfsr_q % 3);
			mreset(1'b1, 1'b0, 1'b0, k[0], 1'b0);
			u_ffs_far_end.gap = 3 + 2 * k;
			wr(36'h0_0000_0000);
			repeat (DEP + 1) wr(rnd());
			repeat (DEP + 2) rd();
			repeat (3) wr(rnd());
			@(negedge clk_in);
			prs_n = 1'b0;
			repeat (6) @(negedge clk_in);
			prs_n = 1'b1;
			repeat (6) @(negedge clk_in);
			cnt = 0;
			q.delete();
			check(ftm, 1'b1);
			chk_flags();
		end
		u_ffs_far_end.gap = 3;
		m_ofs = 32'h0000_0003;
		n_ofs = 32'h0000_0002;
		for (int k = 0; k < 2; k++) begin
			mreset(1'b0, 1'b0, 1'b0, k[0], 1'b0);
			repeat (2) wr(rnd());
			q.push_back(rnd());
			cnt++;
			u_ffs_far_end.write_word(1'b1, q[$]);
			edges(1'b1);
			check(ae_n, !k[0]);
			chk_flags();
			repeat (DEP - 3 - cnt) wr(rnd());
			void'(q.pop_front());
			cnt--;
			u_ffs_far_end.read_word(1'b1);
			edges(1'b0);
			check(af_n, !k[0]);
			chk_flags();
		end
		for (int b = 0; b < 2; b++) begin
			mreset(1'b0, b[0], 1'b1, 1'b1, 1'b0);
			wr(rnd());
			for (int h = 0; h < 2; h++) begin
				u_ffs_far_end.read_word(1'b1);
				repeat (3) @(negedge clk_in);
				check(dout, {18'h0_0000, (h[0] ^ b[0]) ? q[0][17:0] : q[0][35:18]});
			end
		end
		for (int k = 0; k < 2; k++) begin
			mreset(1'b0, 1'b0, 1'b0, 1'b1, k[0]);
			for (int i = 0; i < 3; i++) begin
				ofs_word = (i == 0) ? 36'hF_FFFF_FFFF : rnd();
				load = 1'b1;
				u_ffs_far_end.write_word(1'b1, rnd());
				load = 1'b0;
				edges(1'b0);
				check(parsed, exp_parse(ofs_word, k[0]));
				check(ef_n, 1'b0);
			end
		end
		print_verdict();
	end
endmodule : tb_ffs_flags
